// >>> usbhc_host_channel_xfer.sv
// One host channel: APB registers, event gating and transfer bookkeeping.
//
// How it works
// - An enabled event flag raises the channel interrupt; a disabled one does not.
// - Enable bits are software read-write storage; hardware never changes them.
// - Enable bit 10 toggle error, bit 9 queue overrun, bit 8 babble.
// - Enable bit 7 bus error, bit 5 ACK, bit 4 NAK; bit 6 reserved.
// - Enable bit 3 STALL, bit 1 halted, bit 0 done; others reserved.
// - Data PID codes: 00 DATA0, 10 DATA1, 11 SETUP, 01 reserved.
// - OUT transfers send the first packet with the programmed data PID.
// - IN transfers compare first received PID; mismatch sets toggle error flag.
// - During a transfer hardware alternates the data PID between DATA0 and DATA1.
// - Packet count at bits 28:19 holds packets to move in the transfer.
// - Packet count drops by one after each data packet, even one with an error; it holds at zero.
// - Length at bits 18:0; OUT drops by packet size per transmit FIFO write.
// - IN length drops by packet size per packet read from receive FIFO.
// - Event flags are set by hardware and cleared by writing one.
// - IN transfer raises done flag when packet count hits zero without error.
`timescale 1ns/10ps
module usbhc_host_channel_xfer
  import usbhc_pkg::*;
#(
  parameter int CH_INDEX = 0
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Events from the host packet engine
  input wire logic evtAck,
  input wire logic evtNak,
  input wire logic evtStall,
  input wire logic evtBusError,
  input wire logic evtBabble,
  input wire logic evtQueueOverrun,
  input wire logic evtHalted,
  input wire logic packetDone,
  input wire logic rxPidValid,
  input wire logic [1:0] rxPid,
  input wire logic outStatusPop,
  // FIFO traffic
  input wire logic txFifoWrite,
  input wire logic [10:0] txBytes,
  input wire logic rxFifoRead,
  input wire logic [10:0] rxBytes,
  // Channel outputs
  output logic chanIrq,
  output logic [1:0] txPid,
  output logic xferActive,
  output logic xferDirIn
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [11:0] regAddr(input logic [11:0] base);
    regAddr = base + CH_STRIDE * 12'(CH_INDEX);
  endfunction : regAddr

  function automatic logic [18:0] subSat(input logic [18:0] total, input logic [10:0] amount);
    if (total > 19'(amount)) begin
      subSat = total - 19'(amount);
    end else begin
      subSat = 19'h00000;
    end
  endfunction : subSat

  function automatic logic [1:0] togglePid(input logic [1:0] pid);
    case (pid)
      PID_DATA0: togglePid = PID_DATA1;
      PID_DATA1: togglePid = PID_DATA0;
      PID_SETUP: togglePid = PID_DATA1;
      default: togglePid = PID_DATA0;
    endcase
  endfunction : togglePid

  // ****************************************************************
  // Registers and internal state
  // ****************************************************************
  logic [10:0] enable;
  logic [1:0] dataPidSel;
  logic [9:0] packetCount;
  logic [18:0] transferBytes;
  logic firstPacket;
  logic errorSeen;
  logic [10:0] flags;
  logic [10:0] setFlags;
  logic [10:0] clearFlags;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic hitFlags;
  logic hitEnable;
  logic hitLength;
  logic hitControl;
  logic wordWrite;
  logic wrFlags;
  logic wrEnable;
  logic wrLength;
  logic wrControl;
  logic pidMismatch;
  logic errorNow;
  logic inDone;
  logic outDone;

  // ****************************************************************
  // APB decode
  // ****************************************************************
  assign hitFlags = (paddr == regAddr(OFS_FLAGS));
  assign hitEnable = (paddr == regAddr(OFS_ENABLE));
  assign hitLength = (paddr == regAddr(OFS_LENGTH));
  assign hitControl = (paddr == regAddr(OFS_CONTROL));
  // Partial-strobe writes are refused so no half-updated field can occur.
  assign wordWrite = psel & penable & pready & pwrite & (pstrb == STRB_WORD);
  assign wrFlags = wordWrite & hitFlags;
  assign wrEnable = wordWrite & hitEnable;
  assign wrLength = wordWrite & hitLength;
  assign wrControl = wordWrite & hitControl;

  always_comb begin
    next_prdata = 32'h00000000;
    next_pslverr = 1'b0;
    if (hitFlags) begin
      next_prdata = {21'h000000, flags};
    end else if (hitEnable) begin
      next_prdata = {21'h000000, enable};
    end else if (hitLength) begin
      next_prdata = {1'b0, dataPidSel, packetCount, transferBytes};
    end else if (hitControl) begin
      next_prdata = {23'h000000, xferActive, 6'h00, 1'b0, xferDirIn};
    end else begin
      next_pslverr = 1'b1;
    end
    if (pwrite && pstrb != STRB_WORD) begin
      next_pslverr = 1'b1;
    end
  end

  // The answer is prepared in the setup cycle and stands in the single access cycle.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & next_pslverr;
      prdata <= (psel & ~penable & ~pwrite) ? next_prdata : 32'h00000000;
    end
  end

  // ****************************************************************
  // Enable register
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      enable <= ENABLE_RST;
    end else if (wrEnable) begin
      enable <= pwdata[10:0] & FLAG_MASK;
    end
  end

  // ****************************************************************
  // Transfer control
  // ****************************************************************
  assign pidMismatch = rxPidValid & xferActive & xferDirIn & firstPacket
                     & (rxPid != dataPidSel);
  assign errorNow = xferActive & (evtBusError | evtBabble | evtStall | pidMismatch);
  assign inDone = packetDone & xferActive & xferDirIn & (packetCount == 10'h001)
                & ~errorSeen & ~errorNow;
  assign outDone = outStatusPop & xferActive & ~xferDirIn;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      xferActive <= 1'b0;
      xferDirIn <= 1'b0;
      firstPacket <= 1'b0;
      errorSeen <= 1'b0;
    end else if (wrControl) begin
      xferDirIn <= pwdata[CTL_DIR_IN];
      if (pwdata[CTL_START]) begin
        xferActive <= 1'b1;
        firstPacket <= 1'b1;
        errorSeen <= 1'b0;
      end
    end else begin
      if (inDone || outDone || evtHalted) begin
        xferActive <= 1'b0;
      end
      if (packetDone && xferActive) begin
        firstPacket <= 1'b0;
      end
      if (errorNow) begin
        errorSeen <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Transfer length register
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      dataPidSel <= PID_RST;
      packetCount <= PACKET_COUNT_RST;
      transferBytes <= BYTES_RST;
    end else if (wrLength) begin
      dataPidSel <= pwdata[PID_HI:PID_LO];
      packetCount <= pwdata[PACKET_COUNT_HI:PACKET_COUNT_LO];
      transferBytes <= pwdata[BYTES_HI:0];
    end else if (xferActive) begin
      if (packetDone) begin
        dataPidSel <= togglePid(dataPidSel);
        if (packetCount != PACKET_COUNT_RST) begin
          packetCount <= packetCount - 10'h001;
        end
      end
      if (txFifoWrite && !xferDirIn) begin
        transferBytes <= subSat(transferBytes, txBytes);
      end else if (rxFifoRead && xferDirIn) begin
        transferBytes <= subSat(transferBytes, rxBytes);
      end
    end
  end

  // The PID field is a flop, so the packet engine sees it directly.
  assign txPid = dataPidSel;

  // ****************************************************************
  // Event flags and interrupt
  // ****************************************************************
  always_comb begin
    setFlags = 11'h000;
    setFlags[BIT_DONE] = inDone | outDone;
    setFlags[BIT_HALTED] = evtHalted;
    setFlags[BIT_STALL] = evtStall;
    setFlags[BIT_NAK] = evtNak;
    setFlags[BIT_ACK] = evtAck;
    setFlags[BIT_BUS_ERR] = evtBusError;
    setFlags[BIT_BABBLE] = evtBabble;
    setFlags[BIT_QUEUE_OVR] = evtQueueOverrun;
    setFlags[BIT_TOGGLE_ERR] = pidMismatch;
    clearFlags = wrFlags ? pwdata[10:0] : 11'h000;
  end

  usbhc_event_flags u_flags (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .setFlags(setFlags),
    .clearFlags(clearFlags),
    .enable(enable),
    .flags(flags),
    .irq(chanIrq)
  );

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_enable_sw_only;
    @(posedge sys_clk) disable iff (sys_rst)
      !wrEnable |=> $stable(enable);
  endproperty
  a_enable_sw_only: assert property (p_enable_sw_only)
    else $error("Enable bits changed without a software write.");

  property p_enable_reserved;
    @(posedge sys_clk) disable iff (sys_rst)
      (enable & ~FLAG_MASK) == 11'h000;
  endproperty
  a_enable_reserved: assert property (p_enable_reserved)
    else $error("Reserved enable bit is set.");

  property p_pid_toggles;
    @(posedge sys_clk) disable iff (sys_rst)
      (packetDone && xferActive && !wrLength && dataPidSel == PID_DATA0)
        |=> (dataPidSel == PID_DATA1);
  endproperty
  a_pid_toggles: assert property (p_pid_toggles)
    else $error("Data PID did not toggle to DATA1.");

  property p_toggle_error;
    @(posedge sys_clk) disable iff (sys_rst)
      (rxPidValid && xferActive && xferDirIn && firstPacket && rxPid != dataPidSel)
        |=> flags[BIT_TOGGLE_ERR];
  endproperty
  a_toggle_error: assert property (p_toggle_error)
    else $error("PID mismatch did not raise toggle error.");

  property p_count_down;
    @(posedge sys_clk) disable iff (sys_rst)
      (packetDone && xferActive && !wrLength && packetCount != 10'h000)
        |=> (packetCount == $past(packetCount) - 10'h001);
  endproperty
  a_count_down: assert property (p_count_down)
    else $error("Packet count did not drop by one.");

  property p_out_bytes;
    @(posedge sys_clk) disable iff (sys_rst)
      (txFifoWrite && xferActive && !xferDirIn && !wrLength
        && transferBytes >= 19'(txBytes))
        |=> (transferBytes == $past(transferBytes) - 19'($past(txBytes)));
  endproperty
  a_out_bytes: assert property (p_out_bytes)
    else $error("OUT byte count did not drop by packet size.");

  property p_in_done;
    @(posedge sys_clk) disable iff (sys_rst)
      (xferActive && xferDirIn && packetDone && packetCount == 10'h001
        && !errorSeen && !errorNow && !wrLength && !wrControl)
        |-> ##[1:2] flags[BIT_DONE];
  endproperty
  a_in_done: assert property (p_in_done)
    else $error("IN transfer end did not raise done.");

  property p_apb_answer;
    @(posedge sys_clk) disable iff (sys_rst)
      (psel && !penable) |=> pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("APB access not answered in one cycle.");

  c_in_done: cover property (@(posedge sys_clk) disable iff (sys_rst) inDone);
  c_toggle_err: cover property (@(posedge sys_clk) disable iff (sys_rst) pidMismatch);
  c_out_done: cover property (@(posedge sys_clk) disable iff (sys_rst) outDone);

endmodule : usbhc_host_channel_xfer

// >>> usbhc_pkg.sv
// Shared constants for the USB host channel transfer block.
package usbhc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int ADDR_W = 12;
  localparam logic [11:0] CH_STRIDE = 12'h020;
  localparam logic [11:0] OFS_FLAGS = 12'h508;
  localparam logic [11:0] OFS_ENABLE = 12'h50C;
  localparam logic [11:0] OFS_LENGTH = 12'h510;
  localparam logic [11:0] OFS_CONTROL = 12'h514;

  // ****************************************************************
  // Event flag and enable layout
  // ****************************************************************
  localparam int FLAG_W = 11;
  localparam int BIT_DONE = 0;
  localparam int BIT_HALTED = 1;
  localparam int BIT_STALL = 3;
  localparam int BIT_NAK = 4;
  localparam int BIT_ACK = 5;
  localparam int BIT_BUS_ERR = 7;
  localparam int BIT_BABBLE = 8;
  localparam int BIT_QUEUE_OVR = 9;
  localparam int BIT_TOGGLE_ERR = 10;
  localparam logic [10:0] FLAG_MASK = 11'h7BB;
  localparam logic [10:0] ENABLE_RST = 11'h000;
  localparam logic [10:0] FLAGS_RST = 11'h000;

  // ****************************************************************
  // Transfer length register layout
  // ****************************************************************
  localparam int PID_HI = 30;
  localparam int PID_LO = 29;
  localparam int PACKET_COUNT_HI = 28;
  localparam int PACKET_COUNT_LO = 19;
  localparam int BYTES_HI = 18;
  localparam int PACKET_COUNT_W = 10;
  localparam int BYTES_W = 19;
  localparam int PKT_BYTES_W = 11;
  localparam logic [1:0] PID_RST = 2'h0;
  localparam logic [9:0] PACKET_COUNT_RST = 10'h000;
  localparam logic [18:0] BYTES_RST = 19'h00000;

  // ****************************************************************
  // Data PID codes
  // ****************************************************************
  localparam logic [1:0] PID_DATA0 = 2'h0;
  localparam logic [1:0] PID_RSVD = 2'h1;
  localparam logic [1:0] PID_DATA1 = 2'h2;
  localparam logic [1:0] PID_SETUP = 2'h3;

  // ****************************************************************
  // Control register layout
  // ****************************************************************
  localparam int CTL_DIR_IN = 0;
  localparam int CTL_START = 1;
  localparam int STAT_ACTIVE = 8;
  localparam logic [3:0] STRB_WORD = 4'hF;

endpackage : usbhc_pkg

// >>> usbhc_event_flags.sv
// Sticky channel event flags with write-one-to-clear and the gated interrupt.
`timescale 1ns/10ps
module usbhc_event_flags
  import usbhc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Event and software controls
  input wire logic [10:0] setFlags,
  input wire logic [10:0] clearFlags,
  input wire logic [10:0] enable,
  // Results
  output logic [10:0] flags,
  output logic irq
);

  // ****************************************************************
  // Flags: a set in the same cycle as a clear wins.
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      flags <= FLAGS_RST;
    end else begin
      flags <= ((flags & ~clearFlags) | setFlags) & FLAG_MASK;
    end
  end

  // ****************************************************************
  // Interrupt: any flag whose enable is set, one cycle later.
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags & enable);
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_irq_follows;
    @(posedge sys_clk) disable iff (sys_rst)
      !$past(sys_rst) |-> (irq == |($past(flags) & $past(enable)));
  endproperty
  a_irq_follows: assert property (p_irq_follows)
    else $error("Interrupt does not follow gated flags.");

  property p_masked_silent;
    @(posedge sys_clk) disable iff (sys_rst)
      ((flags & enable) == 11'h000) ##1 ((flags & enable) == 11'h000) |-> !irq;
  endproperty
  a_masked_silent: assert property (p_masked_silent)
    else $error("Interrupt raised with no enabled flag.");

  property p_set_sticks;
    @(posedge sys_clk) disable iff (sys_rst)
      (|(setFlags & FLAG_MASK)) |=> ((flags & $past(setFlags & FLAG_MASK))
                                     == $past(setFlags & FLAG_MASK));
  endproperty
  a_set_sticks: assert property (p_set_sticks)
    else $error("Event did not set its flag.");

  property p_hold_without_clear;
    @(posedge sys_clk) disable iff (sys_rst)
      (clearFlags == 11'h000) |=> ((flags & $past(flags)) == $past(flags));
  endproperty
  a_hold_without_clear: assert property (p_hold_without_clear)
    else $error("Flag dropped without a clear.");

  c_irq_rises: cover property (@(posedge sys_clk) disable iff (sys_rst) $rose(irq));

endmodule : usbhc_event_flags

// >>> usbhc_dev_model.sv
// Behavioural USB device and packet engine that feed events to one host channel.
`timescale 1ns/10ps
module usbhc_dev_model
  import usbhc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Requests from the bench
  input wire logic [3:0] req,
  input wire logic [1:0] reqPid,
  input wire logic [3:0] lag,
  // Answers towards the channel
  output logic [6:0] evt,
  output logic packetDone,
  output logic rxPidValid,
  output logic [1:0] rxPid,
  output logic outStatusPop,
  output logic fired
);
  logic [3:0] pend;
  logic [3:0] cnt;
  logic [1:0] pid;

  // Codes 1 to 7 pulse one event line, 8 is an IN data packet, 9 an OUT packet
  // and 10 pops the OUT finished status; each answer waits lag cycles.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pend <= 4'h0;
      cnt <= 4'h0;
      pid <= 2'h0;
      evt <= 7'h00;
      packetDone <= 1'b0;
      rxPidValid <= 1'b0;
      rxPid <= 2'h0;
      outStatusPop <= 1'b0;
      fired <= 1'b0;
    end else begin
      evt <= 7'h00;
      packetDone <= 1'b0;
      rxPidValid <= 1'b0;
      outStatusPop <= 1'b0;
      fired <= 1'b0;
      rxPid <= ~rxPid;
      if (req != 4'h0) begin
        pend <= req;
        pid <= reqPid;
        cnt <= lag;
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end else if (pend != 4'h0) begin
        pend <= 4'h0;
        fired <= 1'b1;
        if (pend <= 4'h7) begin
          evt[pend - 4'h1] <= 1'b1;
        end
        if (pend == 4'h8) begin
          rxPidValid <= 1'b1;
          rxPid <= pid;
        end
        packetDone <= (pend == 4'h8) || (pend == 4'h9);
        outStatusPop <= (pend == 4'hA);
      end
    end
  end
endmodule : usbhc_dev_model

// >>> tb_usb_host_channel_xfer.sv
// Self-checking bench for one host channel over APB and the device model.
`timescale 1ns/10ps
module tb_usb_host_channel_xfer
  import usbhc_pkg::*;
;
  localparam logic [11:0] BASE = CH_STRIDE + CH_STRIDE;
  localparam logic [11:0] A_FLG = OFS_FLAGS + BASE;
  localparam logic [11:0] A_EN = OFS_ENABLE + BASE;
  localparam logic [11:0] A_LEN = OFS_LENGTH + BASE;
  localparam logic [11:0] A_CTL = OFS_CONTROL + BASE;
  localparam int BITS [7] = '{BIT_ACK, BIT_NAK, BIT_STALL, BIT_BUS_ERR, BIT_BABBLE,
    BIT_QUEUE_OVR, BIT_HALTED};
  logic sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [3:0] pstrb, req, lag;
  logic [1:0] reqPid, rxPid, txPid, c;
  logic [6:0] evt;
  logic packetDone, rxPidValid, outStatusPop, fired, chanIrq, xferActive, xferDirIn;
  logic txFifoWrite, rxFifoRead;
  logic [10:0] txBytes, rxBytes, m;
  int n_fail, checked, i;

  usbhc_host_channel_xfer #(.CH_INDEX(2)) u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .evtAck(evt[0]), .evtNak(evt[1]), .evtStall(evt[2]), .evtBusError(evt[3]),
    .evtBabble(evt[4]), .evtQueueOverrun(evt[5]), .evtHalted(evt[6]),
    .packetDone(packetDone), .rxPidValid(rxPidValid), .rxPid(rxPid),
    .outStatusPop(outStatusPop), .txFifoWrite(txFifoWrite), .txBytes(txBytes),
    .rxFifoRead(rxFifoRead), .rxBytes(rxBytes), .chanIrq(chanIrq), .txPid(txPid),
    .xferActive(xferActive), .xferDirIn(xferDirIn));
  usbhc_dev_model u_dev (.sys_clk(sys_clk), .sys_rst(sys_rst), .req(req),
    .reqPid(reqPid), .lag(lag), .evt(evt), .packetDone(packetDone),
    .rxPidValid(rxPidValid), .rxPid(rxPid), .outStatusPop(outStatusPop), .fired(fired));

  always #25 sys_clk = ~sys_clk;

  // ********
  // Checks and bus tasks
  // ********
  task automatic complete_run;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic hang;
    n_fail++;
    $display("CHECK FAILED at %0t got %h expected %h", $time, 1'b0, 1'b1);
    complete_run();
  endtask : hang

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) hang();
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
    @(posedge sys_clk);
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, STRB_WORD);
    chk_word(rdata, exp);
    chk_bit(rerr, 1'b0);
  endtask : rd

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, STRB_WORD);
    chk_bit(rerr, 1'b0);
  endtask : wr

  task automatic ev(input logic [3:0] k, input logic [1:0] p);
    int n;
    req <= k;
    reqPid <= p;
    @(posedge sys_clk);
    req <= 4'h0;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (fired !== 1'b1 && n < 30);
    if (n >= 30) hang();
    repeat (2) @(posedge sys_clk);
  endtask : ev

  task automatic fifo(input logic rx, input logic [10:0] n);
    txFifoWrite <= ~rx;
    rxFifoRead <= rx;
    txBytes <= n;
    rxBytes <= n;
    @(posedge sys_clk);
    txFifoWrite <= 1'b0;
    rxFifoRead <= 1'b0;
    txBytes <= ~n;
    rxBytes <= ~n;
    @(posedge sys_clk);
  endtask : fifo

  function automatic logic [31:0] len(input logic [1:0] p, input logic [9:0] k,
                                      input logic [18:0] b);
    return {1'b0, p, k, b};
  endfunction : len

  // ********
  // Main sequence
  // ********
  initial begin
    sys_clk = 0; sys_rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 12'h000;
    pwdata = 32'h0; pstrb = 4'h0; req = 4'h0; reqPid = 2'h0; lag = 4'h0;
    txFifoWrite = 0; rxFifoRead = 0; txBytes = 11'h000; rxBytes = 11'h000;
    n_fail = 0; checked = 0;
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    rd(A_EN, 32'h0);
    rd(A_LEN, 32'h0);
    rd(A_FLG, 32'h0);
    wr(A_EN, 32'hFFFFFFFF);
    rd(A_EN, {21'h0, FLAG_MASK});
    apb(1'b1, A_EN, 32'h0, 4'h1);
    chk_bit(rerr, 1'b1);
    rd(A_EN, {21'h0, FLAG_MASK});
    apb(1'b0, 12'h000, 32'h0, STRB_WORD);
    chk_bit(rerr, 1'b1);
    chk_word(rdata, 32'h0);
    wr(A_FLG, 32'h7FF);
    rd(A_FLG, 32'h0);
    for (i = 1; i <= 7; i++) begin
      m = 11'h001 << BITS[i-1];
      lag <= 4'(i % 3);
      wr(A_EN, {21'h0, m});
      ev(4'(i), 2'h0);
      chk_bit(chanIrq, 1'b1);
      rd(A_FLG, {21'h0, m});
      wr(A_FLG, {21'h0, m});
      @(posedge sys_clk);
      chk_bit(chanIrq, 1'b0);
      wr(A_EN, {21'h0, FLAG_MASK & ~m});
      ev(4'(i), 2'h0);
      chk_bit(chanIrq, 1'b0);
      rd(A_FLG, {21'h0, m});
      rd(A_EN, {21'h0, FLAG_MASK & ~m});
      wr(A_FLG, {21'h0, m});
    end
    // IN transfer of two packets with a receive FIFO read between them.
    wr(A_EN, 32'h1);
    wr(A_LEN, len(PID_DATA0, 10'd2, 19'd100));
    wr(A_CTL, 32'h3);
    chk_bit(xferActive, 1'b1);
    chk_bit(xferDirIn, 1'b1);
    rd(A_CTL, 32'h101);
    ev(4'h8, PID_DATA0);
    rd(A_LEN, len(PID_DATA1, 10'd1, 19'd100));
    fifo(1'b1, 11'd60);
    rd(A_LEN, len(PID_DATA1, 10'd1, 19'd40));
    ev(4'h8, PID_DATA1);
    chk_bit(chanIrq, 1'b1);
    chk_bit(xferActive, 1'b0);
    rd(A_FLG, 32'h1);
    rd(A_LEN, len(PID_DATA0, 10'd0, 19'd40));
    rd(A_CTL, 32'h1);
    wr(A_FLG, 32'h1);
    // IN transfer whose first packet carries the wrong PID, then halted.
    wr(A_LEN, len(PID_DATA1, 10'd1, 19'd8));
    wr(A_CTL, 32'h3);
    ev(4'h8, PID_DATA0);
    chk_bit(chanIrq, 1'b0);
    rd(A_FLG, 32'h400);
    ev(4'h7, 2'h0);
    rd(A_CTL, 32'h1);
    wr(A_FLG, 32'h7FF);
    // OUT transfers started with every PID code.
    for (i = 0; i < 4; i++) begin
      c = 2'(i);
      wr(A_LEN, len(c, 10'd1, 19'd8));
      wr(A_CTL, 32'h2);
      chk_bit(xferDirIn, 1'b0);
      chk_word({30'h0, txPid}, {30'h0, c});
      fifo(1'b0, 11'd8);
      rd(A_LEN, len(c, 10'd1, 19'd0));
      ev(4'h9, 2'h0);
      rd(A_LEN, len((c == PID_DATA0 || c == PID_SETUP) ? PID_DATA1 : PID_DATA0,
         10'd0, 19'd0));
      ev(4'hA, 2'h0);
      rd(A_FLG, 32'h1);
      wr(A_FLG, 32'h1);
    end
    // A reset in mid-run clears the registers, the transfer and the interrupt.
    wr(A_EN, {21'h0, FLAG_MASK});
    wr(A_CTL, 32'h3);
    ev(4'h1, 2'h0);
    chk_bit(chanIrq, 1'b1);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    chk_bit(chanIrq, 1'b0);
    chk_bit(xferActive, 1'b0);
    rd(A_EN, 32'h0);
    rd(A_FLG, 32'h0);
    rd(A_LEN, 32'h0);
    complete_run();
  end
endmodule : tb_usb_host_channel_xfer
